// ===== bench/link_status_general_pin_zero_regs_tb_top.sv
// Self-checking bench of the link status slice
`timescale 1ns/10ps
`default_nettype none
module link_status_general_pin_zero_regs_tb_top;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] d;
      logic err;
      logic [1:0] pin;
   } lsg_row_s;
   localparam logic [3:0] REV = 4'h1;
   logic ref_clk, reset_n, psel, penable, pwrite, pslverr, pready, go, port, clk_ok, irq;
   logic busy, pin0, oe0, pin1, oe1, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [1:0] link_up, value, link_det, crc_ev, rgpio, bist_act, bist_go;
   logic [16:0] len;
   int bad_count, samples_checked;
   lsg_row_s rows [24] = '{
      '{0, 8'h34, {REV, 4'h0}, 0, 2'b00}, '{0, 8'h28, 8'h00, 0, 2'b00},
      '{0, 8'h2c, 8'h00, 0, 2'b00}, '{0, 8'h30, 8'h05, 0, 2'b00},
      '{1, 8'h28, 8'hff, 0, 2'b00}, '{0, 8'h28, 8'h00, 0, 2'b00},
      '{0, 8'hfc, 8'h00, 1, 2'b00}, '{0, 8'h29, 8'h00, 1, 2'b00},
      '{1, 8'h10, 8'h20, 0, 2'b00}, '{0, 8'h10, 8'h00, 0, 2'b00},
      '{1, 8'h44, 8'hff, 0, 2'b00}, '{0, 8'h44, 8'h0f, 0, 2'b00},
      '{1, 8'h44, 8'h00, 0, 2'b00}, '{1, 8'h34, 8'h08, 0, 2'b00},
      '{1, 8'h34, 8'h09, 0, 2'b11}, '{1, 8'h34, 8'h0a, 0, 2'b00},
      '{1, 8'h34, 8'h0b, 0, 2'b00}, '{1, 8'h34, 8'h0c, 0, 2'b00},
      '{1, 8'h34, 8'h0d, 0, 2'b10}, '{1, 8'h34, 8'h0e, 0, 2'b00},
      '{1, 8'h34, 8'h0f, 0, 2'b10}, '{0, 8'h34, {REV, 4'hf}, 0, 2'b10},
      '{1, 8'h34, 8'he9, 0, 2'b11}, '{0, 8'h34, {REV, 4'h9}, 0, 2'b11}};
   lsg_link_status #(.REVISION_ID(REV)) u_lsg_link_status (.ref_clk_i(ref_clk),
      .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .link_detect_i(link_det), .input_clock_present_i(clk_ok),
      .crc_error_event_i(crc_ev), .bist_active_i(bist_act), .bist_start_i(bist_go),
      .remote_general_pin_zero_i(rgpio), .general_pin_zero_o(pin0), .general_pin_zero_oe_o(oe0),
      .second_port_general_pin_zero_pin_o(pin1), .second_port_general_pin_zero_pin_oe_o(oe1), .irq_o(irq));
   lsg_remote_model u_lsg_remote_model (.clk_i(ref_clk), .reset_n_i(reset_n),
      .link_up_i(link_up), .value_i(value), .go_i(go), .port_i(port), .len_i(len),
      .link_detect_o(link_det), .crc_error_event_o(crc_ev), .remote_general_pin_zero_o(rgpio),
      .busy_o(busy));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("BAD t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Starts after an edge, so no signal is driven twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         results();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(rdat, {24'h000000, e});
   endtask
   task automatic burst(input logic p, input logic [16:0] n);
      @(posedge ref_clk);
      port <= p;
      len <= n;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      for (int i = 0; i < 70000 && (i == 0 || busy); i++) cyc(1);
      if (busy !== 1'b0) begin
         bad_count++;
         results();
      end
      cyc(3);
   endtask
   initial begin
      cyc(90000);
      bad_count++;
      results();
   end
   initial begin
      {reset_n, psel, penable, pwrite, go, port, clk_ok} = 7'h01;
      {paddr, pwdata, len, value, bist_act, bist_go} = '0;
      link_up = 2'b11;
      bad_count = 0;
      samples_checked = 0;
      cyc(4);
      reset_n <= 1'b1;
      cyc(6);
      for (int i = 0; i < 24; i++) begin
         apb(rows[i].wr, rows[i].addr, rows[i].d);
         chk(rerr, rows[i].err);
         if (!rows[i].wr) chk(rdat, {24'h000000, rows[i].d});
         cyc(2);
         chk({oe0, oe0 & pin0}, rows[i].pin);
      end
      $display("register table done");
      burst(1'b0, 17'h00003);
      rd(8'h28, 8'h03);
      rd(8'h30, 8'h07);
      apb(1'b1, 8'h44, 8'h04);
      cyc(2);
      chk(irq, 1'b1);
      rd(8'h40, 8'h04);
      cyc(2);
      chk(irq, 1'b0);
      apb(1'b1, 8'h44, 8'h00);
      burst(1'b0, 17'h00001);
      chk(irq, 1'b0);
      rd(8'h40, 8'h04);
      $display("errors and interrupt done");
      bist_act <= 2'b01;
      burst(1'b0, 17'h00001);
      rd(8'h30, 8'h0f);
      rd(8'h28, 8'h05);
      bist_act <= 2'b00;
      bist_go <= 2'b01;
      cyc(1);
      bist_go <= 2'b00;
      cyc(2);
      rd(8'h30, 8'h07);
      apb(1'b1, 8'h10, 8'h20);
      rd(8'h28, 8'h00);
      rd(8'h2c, 8'h00);
      rd(8'h30, 8'h05);
      $display("self-test and reset done");
      apb(1'b1, 8'h10, 8'h01);
      burst(1'b1, 17'h00002);
      rd(8'h28, 8'h02);
      apb(1'b1, 8'h34, 8'h01);
      cyc(2);
      chk({oe1, pin1, oe0, pin0}, 4'b1011);
      clk_ok <= 1'b0;
      cyc(6);
      rd(8'h30, 8'h03);
      clk_ok <= 1'b1;
      apb(1'b1, 8'h10, 8'h20);
      $display("second port done");
      burst(1'b0, 17'h10001);
      rd(8'h28, 8'hff);
      rd(8'h2c, 8'hff);
      $display("saturation done");
      apb(1'b1, 8'h34, 8'h05);
      value <= 2'b01;
      bist_act <= 2'b01;
      burst(1'b0, 17'h00001);
      bist_act <= 2'b00;
      chk({oe0, pin0}, 2'b11);
      rd(8'h40, 8'h0c);
      link_up <= 2'b10;
      cyc(6);
      chk({oe0, pin0}, 2'b11);
      rd(8'h30, 8'h14);
      rd(8'h40, 8'h01);
      apb(1'b1, 8'h34, 8'h0f);
      cyc(2);
      chk({oe0, pin0}, 2'b11);
      apb(1'b1, 8'h34, 8'h07);
      cyc(2);
      chk({oe0, pin0}, 2'b10);
      link_up <= 2'b11;
      cyc(6);
      rd(8'h30, 8'h15);
      apb(1'b1, 8'h10, 8'h20);
      rd(8'h30, 8'h05);
      $display("link loss done");
      // Mid-run reset with a live count and pending interrupt state
      burst(1'b0, 17'h00002);
      reset_n <= 1'b0;
      cyc(2);
      reset_n <= 1'b1;
      cyc(4);
      chk({oe0, pin0, irq}, 3'b000);
      rd(8'h28, 8'h00);
      rd(8'h34, {REV, 4'h0});
      rd(8'h30, 8'h05);
      rd(8'h40, 8'h00);
      $display("mid-run reset done");
      results();
   end
endmodule
`default_nettype wire

// ===== bench/lsg_remote_model.sv
// Behavioural remote deserializer for the link status slice
`timescale 1ns/10ps
`default_nettype none
module lsg_remote_model (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [1:0] link_up_i,
   input wire logic [1:0] value_i,
   input wire logic go_i,
   input wire logic port_i,
   input wire logic [16:0] len_i,
   output logic [1:0] link_detect_o,
   output logic [1:0] crc_error_event_o,
   output logic [1:0] remote_general_pin_zero_o,
   output logic busy_o
);
   logic [16:0] left;
   logic [1:0] last;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         left <= 17'h00000;
      end else if (go_i) begin
         left <= len_i;
      end else if (busy_o) begin
         left <= left - 17'h00001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         last <= 2'h0;
      end else begin
         last <= remote_general_pin_zero_o;
      end
   end
   // Dead link toggles, so a held value cannot pass by luck
   assign remote_general_pin_zero_o = (link_up_i & value_i) | (~link_up_i & ~last);
   assign link_detect_o = link_up_i;
   // Errors only reach a live link
   assign crc_error_event_o = (busy_o && link_up_i[port_i]) ? (2'h1 << port_i) : 2'h0;
   assign busy_o = left != 17'h00000;
endmodule
`default_nettype wire

// ===== common/lsg_pkg.sv
// Types shared by the link status slice
package lsg_pkg;
   typedef logic [2:0] lsg_mode_t;
   typedef enum logic [2:0] {
      LSG_GP_OUT = 3'h1,
      LSG_GP_IN = 3'h3,
      LSG_REMOTE_HOLD = 3'h5,
      LSG_REMOTE_DEFAULT = 3'h7
   } lsg_gpio_mode_e;
endpackage

// ===== common/lsg_regs.svh
// Register indices, field positions and reset values of the link status slice
`ifndef LSG_REGS_SVH
`define LSG_REGS_SVH
`define LSG_IDX_CTRL 6'h04
`define LSG_IDX_CRC_LO 6'h0a
`define LSG_IDX_CRC_HI 6'h0b
`define LSG_IDX_STATUS 6'h0c
`define LSG_IDX_CONFIG 6'h0d
`define LSG_IDX_IRQ_STAT 6'h10
`define LSG_IDX_IRQ_MASK 6'h11
`define LSG_CTRL_PORT_SEL 0
`define LSG_CTRL_CRC_RESET 5
`define LSG_ST_LINK 0
`define LSG_ST_DES_ERR 1
`define LSG_ST_CLK 2
`define LSG_ST_BIST_ERR 3
`define LSG_ST_LOST 4
`define LSG_CFG_VALUE 3
`define LSG_CFG_REV_LSB 4
`define LSG_CNT_RESET 16'h0000
`define LSG_CNT_MAX 16'hffff
`define LSG_CFG_RESET 4'h0
`define LSG_IRQ_W 4
`define LSG_IRQ_LOST0 0
`define LSG_IRQ_ERR0 2
`endif

// ===== rtl/lsg_link_status.sv
// Link status, back-channel error counter and pin-zero configuration slice
`include "lsg_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module lsg_link_status #(
   parameter logic [3:0] REVISION_ID = 4'h1
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [1:0] link_detect_i,
   input wire logic input_clock_present_i,
   input wire logic [1:0] crc_error_event_i,
   input wire logic [1:0] bist_active_i,
   input wire logic [1:0] bist_start_i,
   input wire logic [1:0] remote_general_pin_zero_i,
   output logic general_pin_zero_o,
   output logic general_pin_zero_oe_o,
   output logic second_port_general_pin_zero_pin_o,
   output logic second_port_general_pin_zero_pin_oe_o,
   output logic irq_o
);
   // Revision value is arbitrary

   logic [1:0] link_meta;
   logic [1:0] link_sync;
   logic [1:0] link_prev;
   logic clk_meta;
   logic clk_sync;
   logic second_port_select;
   logic [15:0] crc_count [2];
   logic [1:0] link_lost;
   logic [1:0] bist_err;
   logic [1:0] des_err;
   logic [3:0] cfg [2];
   logic [1:0] remote_held;
   logic [`LSG_IRQ_W-1:0] irq_status;
   logic [`LSG_IRQ_W-1:0] irq_mask;
   logic [1:0] next_pin;
   logic [1:0] next_oe;
   logic [31:0] next_rdata;
   logic next_err;
   logic setup;
   logic wr;
   logic rd;
   logic crc_reset;
   logic [1:0] loss_event;
   logic sel;

   function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
      hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
   endfunction

   function automatic logic mapped(input logic [7:0] addr);
      mapped = hit(addr, `LSG_IDX_CTRL) || hit(addr, `LSG_IDX_CRC_LO) ||
         hit(addr, `LSG_IDX_CRC_HI) || hit(addr, `LSG_IDX_STATUS) ||
         hit(addr, `LSG_IDX_CONFIG) || hit(addr, `LSG_IDX_IRQ_STAT) ||
         hit(addr, `LSG_IDX_IRQ_MASK);
   endfunction

   assign setup = psel_i && !penable_i;
   assign wr = psel_i && penable_i && pready_o && pwrite_i;
   assign rd = psel_i && penable_i && pready_o && !pwrite_i;
   assign crc_reset = wr && hit(paddr_i, `LSG_IDX_CTRL) && pwdata_i[`LSG_CTRL_CRC_RESET];
   assign loss_event = link_prev & ~link_sync;
   assign sel = second_port_select;

   // Link and clock detect pins cross in from outside; two stages before any use
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         link_meta <= 2'h0;
         link_sync <= 2'h0;
         clk_meta <= 1'b0;
         clk_sync <= 1'b0;
      end else begin
         link_meta <= link_detect_i;
         link_sync <= link_meta;
         clk_meta <= input_clock_present_i;
         clk_sync <= clk_meta;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         link_prev <= 2'h0;
      end else begin
         link_prev <= link_sync;
      end
   end

   // Reset bit self-clears, so it always reads back 0
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         second_port_select <= 1'b0;
      end else if (wr && hit(paddr_i, `LSG_IDX_CTRL)) begin
         second_port_select <= pwdata_i[`LSG_CTRL_PORT_SEL];
      end
   end

   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         always_ff @(posedge ref_clk_i) begin
            if (!reset_n_i) begin
               crc_count[p] <= `LSG_CNT_RESET;
            end else if (crc_reset) begin
               crc_count[p] <= crc_error_event_i[p] ? 16'h0001 : `LSG_CNT_RESET;
            end else if (crc_error_event_i[p] && crc_count[p] != `LSG_CNT_MAX) begin
               crc_count[p] <= crc_count[p] + 16'h0001;
            end
         end

         // Set wins over the software clear so no loss is missed
         always_ff @(posedge ref_clk_i) begin
            if (!reset_n_i) begin
               link_lost[p] <= 1'b0;
            end else if (loss_event[p]) begin
               link_lost[p] <= 1'b1;
            end else if (crc_reset) begin
               link_lost[p] <= 1'b0;
            end
         end

         always_ff @(posedge ref_clk_i) begin
            if (!reset_n_i) begin
               bist_err[p] <= 1'b0;
            end else if (crc_error_event_i[p] && bist_active_i[p]) begin
               bist_err[p] <= 1'b1;
            end else if (loss_event[p] || bist_start_i[p] || crc_reset) begin
               bist_err[p] <= 1'b0;
            end
         end

         always_ff @(posedge ref_clk_i) begin
            if (!reset_n_i) begin
               des_err[p] <= 1'b0;
            end else if (crc_error_event_i[p] && !bist_active_i[p]) begin
               des_err[p] <= 1'b1;
            end else if (loss_event[p] || crc_reset) begin
               des_err[p] <= 1'b0;
            end
         end

         always_ff @(posedge ref_clk_i) begin
            if (!reset_n_i) begin
               cfg[p] <= `LSG_CFG_RESET;
            end else if (wr && hit(paddr_i, `LSG_IDX_CONFIG) && sel == 1'(p)) begin
               cfg[p] <= pwdata_i[3:0];
            end
         end

         // Last remote value is only refreshed while the link is up
         always_ff @(posedge ref_clk_i) begin
            if (!reset_n_i) begin
               remote_held[p] <= 1'b0;
            end else if (link_sync[p]) begin
               remote_held[p] <= remote_general_pin_zero_i[p];
            end
         end

         always_comb begin
            next_pin[p] = 1'b0;
            next_oe[p] = 1'b0;
            case (cfg[p][2:0])
               lsg_pkg::LSG_GP_OUT: begin
                  next_pin[p] = cfg[p][`LSG_CFG_VALUE];
                  next_oe[p] = 1'b1;
               end
               lsg_pkg::LSG_GP_IN: begin
                  next_oe[p] = 1'b0;
               end
               lsg_pkg::LSG_REMOTE_HOLD: begin
                  next_pin[p] = link_sync[p] ? remote_general_pin_zero_i[p] : remote_held[p];
                  next_oe[p] = 1'b1;
               end
               lsg_pkg::LSG_REMOTE_DEFAULT: begin
                  next_pin[p] = link_sync[p] ? remote_general_pin_zero_i[p] :
                     cfg[p][`LSG_CFG_VALUE];
                  next_oe[p] = 1'b1;
               end
               default: begin
                  next_oe[p] = 1'b0;
               end
            endcase
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         general_pin_zero_o <= 1'b0;
         general_pin_zero_oe_o <= 1'b0;
         second_port_general_pin_zero_pin_o <= 1'b0;
         second_port_general_pin_zero_pin_oe_o <= 1'b0;
      end else begin
         general_pin_zero_o <= next_pin[0];
         general_pin_zero_oe_o <= next_oe[0];
         second_port_general_pin_zero_pin_o <= next_pin[1];
         second_port_general_pin_zero_pin_oe_o <= next_oe[1];
      end
   end

   // Read clears status; a new event in the same cycle stays set
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         irq_status <= 4'h0;
      end else begin
         irq_status <= ((rd && hit(paddr_i, `LSG_IDX_IRQ_STAT)) ? 4'h0 : irq_status) |
            {crc_error_event_i, loss_event};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         irq_mask <= 4'h0;
      end else if (wr && hit(paddr_i, `LSG_IDX_IRQ_MASK)) begin
         irq_mask <= pwdata_i[`LSG_IRQ_W-1:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_mask);
      end
   end

   always_comb begin
      next_rdata = 32'h0;
      next_err = !mapped(paddr_i);
      if (hit(paddr_i, `LSG_IDX_CTRL)) begin
         next_rdata[`LSG_CTRL_PORT_SEL] = second_port_select;
      end else if (hit(paddr_i, `LSG_IDX_CRC_LO)) begin
         next_rdata[7:0] = crc_count[sel][7:0];
      end else if (hit(paddr_i, `LSG_IDX_CRC_HI)) begin
         next_rdata[7:0] = crc_count[sel][15:8];
      end else if (hit(paddr_i, `LSG_IDX_STATUS)) begin
         next_rdata[`LSG_ST_LINK] = link_sync[sel];
         next_rdata[`LSG_ST_DES_ERR] = des_err[sel];
         next_rdata[`LSG_ST_CLK] = clk_sync;
         next_rdata[`LSG_ST_BIST_ERR] = bist_err[sel];
         next_rdata[`LSG_ST_LOST] = link_lost[sel];
      end else if (hit(paddr_i, `LSG_IDX_CONFIG)) begin
         next_rdata[7:0] = {REVISION_ID, cfg[sel]};
      end else if (hit(paddr_i, `LSG_IDX_IRQ_STAT)) begin
         next_rdata[`LSG_IRQ_W-1:0] = irq_status;
      end else if (hit(paddr_i, `LSG_IDX_IRQ_MASK)) begin
         next_rdata[`LSG_IRQ_W-1:0] = irq_mask;
      end
   end

   // Zero-wait slave: answer prepared in setup, presented in access
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0;
      end else begin
         pready_o <= setup;
         pslverr_o <= setup && next_err;
         prdata_o <= setup ? next_rdata : 32'h0;
      end
   end

   property p_count_step;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (crc_error_event_i[0] && !crc_reset && crc_count[0] != `LSG_CNT_MAX)
         |=> crc_count[0] == $past(crc_count[0]) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter did not step");

   property p_count_clear;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (crc_reset && !crc_error_event_i[1]) |=> crc_count[1] == 16'h0000;
   endproperty
   a_count_clear: assert property (p_count_clear) else $error("counter not cleared");

   property p_lost_sticky;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (link_lost[0] && !crc_reset) |=> link_lost[0];
   endproperty
   a_lost_sticky: assert property (p_lost_sticky) else $error("link lost flag dropped");

   property p_loss_sets;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      ($fell(link_sync[0]) && !crc_error_event_i[0]) |=> link_lost[0] && !des_err[0];
   endproperty
   a_loss_sets: assert property (p_loss_sets) else $error("loss handling wrong");

   property p_bist_set;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (crc_error_event_i[0] && bist_active_i[0]) |=> bist_err[0];
   endproperty
   a_bist_set: assert property (p_bist_set) else $error("self-test error not set");

   property p_bist_clear;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (bist_start_i[0] && !crc_error_event_i[0]) |=> !bist_err[0];
   endproperty
   a_bist_clear: assert property (p_bist_clear) else $error("self-test error kept");

   property p_saturate;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (crc_count[0] == `LSG_CNT_MAX && !crc_reset) |=> crc_count[0] == `LSG_CNT_MAX;
   endproperty
   a_saturate: assert property (p_saturate) else $error("counter wrapped");

   property p_gp_out;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (cfg[0] == 4'h9) ##1 (cfg[0] == 4'h9) |-> general_pin_zero_oe_o && general_pin_zero_o;
   endproperty
   a_gp_out: assert property (p_gp_out) else $error("pin not driven high");

   property p_hiz;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (cfg[0][1:0] == 2'h2) |=> !general_pin_zero_oe_o;
   endproperty
   a_hiz: assert property (p_hiz) else $error("pin driven in high impedance mode");

   property p_remote_default;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (cfg[0][2:0] == 3'h7 && !link_sync[0]) |=>
         general_pin_zero_o == $past(cfg[0][`LSG_CFG_VALUE]);
   endproperty
   a_remote_default: assert property (p_remote_default) else $error("default not used");

   property p_irq;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      |(irq_status & irq_mask) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule
`default_nettype wire
